// [design/pll_status_control_regs.sv]
// Register front end that reports PLL status and drives PLL reset, detector enable and phase steps.
//
// Notes on behaviour
// - Registers are 32 or 16 bits wide.
// - Reduced variant maps only selected bits.
// - Writing status register changes nothing.
// - Status bit 0 shows lock, resets 1.
// - Status bit 1 synchronised shift-done, resets 0.
// - Raw lock and done also exported.
// - Control register reads back written bits.
// - Control bit 0 requests PLL reset.
// - PLL reset request drives only the PLL reset pin.
// - Control bit 1 enables detector, resets 1.
// - Phase register bits 8:0 select counter.
// - Step field: 01 up, 10 down.
// - Phase stepping exists in full variant only.
// - Select codes: all outputs, feedback, outputs 0-9.
`timescale 1ns/10ps
`default_nettype none

module pll_status_control_regs
   import pll_regs_pkg::*;
#(
   parameter bit FULL_VARIANT = 1'b1,
   parameter bit LOCK_MAPPED  = 1'b1,
   parameter bit DONE_MAPPED  = 1'b1,
   parameter bit RESET_MAPPED = 1'b1,
   parameter bit PFD_MAPPED   = 1'b1,
   parameter int DATA_W       = FULL_VARIANT ? pll_regs_pkg::FULL_DATA_W
                                             : pll_regs_pkg::REDUCED_DATA_W
) (
   input  wire  logic                               ref_clk,
   input  wire  logic                               rst,
   input  wire  logic [pll_regs_pkg::ADDR_W-1:0]    address,
   input  wire  logic                               read,
   input  wire  logic                               write,
   input  wire  logic [DATA_W-1:0]                  writeData,
   output var   logic [DATA_W-1:0]                  readData_r,
   output var   logic                               readValid_r,
   input  wire  logic                               pllLocked,
   input  wire  logic                               pllShiftDone,
   input  wire  logic                               extResetReq,
   input  wire  logic                               extPfdEnable,
   output wire  logic                               lockedConduit,
   output wire  logic                               shiftDoneConduit,
   output var   logic                               pllReset_r,
   output var   logic                               pfdEnable_r,
   output var   logic                               phaseStep_r,
   output var   logic                               phaseUp_r,
   output var   logic [pll_regs_pkg::SEL_W-1:0]     stepSel_r,
   output var   logic [pll_regs_pkg::MASK_W-1:0]    stepMask_r
);
   import pll_regs_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic              lockMeta_r;
   logic              lockSync_r;
   logic              doneMeta_r;
   logic              doneSync_r;
   logic              extRstMeta_r;
   logic              extRstSync_r;
   logic              extPfdMeta_r;
   logic              extPfdSync_r;
   logic              resetBit_r;
   logic              pfdBit_r;
   logic [SEL_W-1:0]  selField_r;
   logic [STEP_W-1:0] stepField_r;
   logic [31:0]       wrWord;
   logic [31:0]       rdWord;
   logic              wrControl;
   logic              wrPhase;
   logic              stepReq;
   logic [MASK_W-1:0] maskNxt;
   logic              resetNxt;
   logic              pfdNxt;

   // ----------------------------------------------------------------
   // Raw conduits
   // ----------------------------------------------------------------
   // These bypass the synchronisers on purpose; users in other domains sync them themselves.
   assign lockedConduit    = pllLocked;
   assign shiftDoneConduit = pllShiftDone;

   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   // PLL outputs and exported control pins are asynchronous, so each passes two stages.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lockMeta_r   <= LOCK_RST;
         lockSync_r   <= LOCK_RST;
         doneMeta_r   <= DONE_RST;
         doneSync_r   <= DONE_RST;
         extRstMeta_r <= RESET_RST;
         extRstSync_r <= RESET_RST;
         extPfdMeta_r <= PFD_RST;
         extPfdSync_r <= PFD_RST;
      end else begin
         lockMeta_r   <= pllLocked;
         lockSync_r   <= lockMeta_r;
         doneMeta_r   <= pllShiftDone;
         doneSync_r   <= doneMeta_r;
         extRstMeta_r <= extResetReq;
         extRstSync_r <= extRstMeta_r;
         extPfdMeta_r <= extPfdEnable;
         extPfdSync_r <= extPfdMeta_r;
      end
   end

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   // The status index has no write strobe at all, so status writes are inert.
   assign wrWord    = 32'(writeData);
   assign wrControl = write && (address == PLL_CONTROL_IDX);
   assign wrPhase   = write && (address == PHASE_STEP_CONTROL_IDX) && FULL_VARIANT;
   assign stepReq   = wrPhase && ((wrWord[STEP_LSB +: STEP_W] == STEP_UP) ||
                                  (wrWord[STEP_LSB +: STEP_W] == STEP_DOWN));

   // ----------------------------------------------------------------
   // Control and phase registers
   // ----------------------------------------------------------------
   // In the reduced variant an unmapped bit is never stored; its pin drives the PLL instead.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         resetBit_r  <= RESET_RST;
         pfdBit_r    <= PFD_RST;
         selField_r  <= SEL_RST;
         stepField_r <= STEP_RST;
      end else begin
         if (wrControl && (FULL_VARIANT || RESET_MAPPED)) begin
            resetBit_r <= wrWord[RESET_BIT];
         end
         if (wrControl && (FULL_VARIANT || PFD_MAPPED)) begin
            pfdBit_r <= wrWord[PFD_BIT];
         end
         if (wrPhase) begin
            selField_r  <= wrWord[SEL_LSB +: SEL_W];
            stepField_r <= wrWord[STEP_LSB +: STEP_W];
         end
      end
   end

   // ----------------------------------------------------------------
   // PLL control drive
   // ----------------------------------------------------------------
   assign resetNxt = (FULL_VARIANT || RESET_MAPPED) ? resetBit_r : extRstSync_r;
   assign pfdNxt   = (FULL_VARIANT || PFD_MAPPED)   ? pfdBit_r   : extPfdSync_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pllReset_r  <= RESET_RST;
         pfdEnable_r <= PFD_RST;
      end else begin
         pllReset_r  <= resetNxt;
         pfdEnable_r <= pfdNxt;
      end
   end

   // ----------------------------------------------------------------
   // Counter select decode
   // ----------------------------------------------------------------
   // Bits 0..9 are output counters, the top bit the feedback counter; undefined codes step none.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_OUT_CNT; gi++) begin : g_out_sel
         assign maskNxt[gi] = (wrWord[SEL_LSB +: SEL_W] == SEL_ALL_OUT) ||
                              (wrWord[SEL_LSB +: SEL_W] == (SEL_OUT_BASE + 9'(gi)));
      end
   endgenerate
   assign maskNxt[NUM_OUT_CNT] = (wrWord[SEL_LSB +: SEL_W] == SEL_FEEDBACK);

   // ----------------------------------------------------------------
   // Phase step request
   // ----------------------------------------------------------------
   // One pulse per accepted write; a no-op code leaves the port idle.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phaseStep_r <= 1'b0;
         phaseUp_r   <= 1'b0;
         stepSel_r   <= SEL_RST;
         stepMask_r  <= '0;
      end else begin
         phaseStep_r <= stepReq;
         if (stepReq) begin
            phaseUp_r  <= (wrWord[STEP_LSB +: STEP_W] == STEP_UP);
            stepSel_r  <= wrWord[SEL_LSB +: SEL_W];
            stepMask_r <= maskNxt;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Reserved and unmapped bits read as zero; index 3 reads all zero.
   always_comb begin
      rdWord = 32'h0000_0000;
      case (address)
         PLL_STATUS_IDX: begin
            rdWord[LOCK_BIT] = lockSync_r & (FULL_VARIANT | LOCK_MAPPED);
            rdWord[DONE_BIT] = doneSync_r & (FULL_VARIANT | DONE_MAPPED);
         end
         PLL_CONTROL_IDX: begin
            rdWord[RESET_BIT] = resetBit_r & (FULL_VARIANT | RESET_MAPPED);
            rdWord[PFD_BIT]   = pfdBit_r & (FULL_VARIANT | PFD_MAPPED);
         end
         PHASE_STEP_CONTROL_IDX: begin
            if (FULL_VARIANT) begin
               rdWord[SEL_LSB +: SEL_W]   = selField_r;
               rdWord[STEP_LSB +: STEP_W] = stepField_r;
            end
         end
         default: rdWord = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         readData_r  <= '0;
         readValid_r <= 1'b0;
      end else begin
         readValid_r <= read;
         if (read) begin
            readData_r <= rdWord[DATA_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_status_write_inert: assert property (
      (write && address == PLL_STATUS_IDX && !wrControl) |=> $stable(resetBit_r) && $stable(pfdBit_r)
         && $stable(selField_r) && !phaseStep_r)
      else $error("status write changed state");

   a_lock_after_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
      rst |=> lockSync_r == 1'b1 && doneSync_r == 1'b0)
      else $error("status reset values wrong");

   a_done_two_stage: assert property (
      !$past(rst) && !$past(rst, 2) |-> doneSync_r == $past(pllShiftDone, 2))
      else $error("shift-done not two stages late");

   a_reset_write: assert property (
      (wrControl && FULL_VARIANT) |=> resetBit_r == $past(wrWord[RESET_BIT])
         ##1 pllReset_r == $past(resetBit_r))
      else $error("reset request not driven");

   a_pfd_reset_one: assert property (@(posedge ref_clk) disable iff (1'b0)
      rst |=> pfdEnable_r && pfdBit_r && !pllReset_r)
      else $error("detector enable reset value wrong");

   a_ctrl_readback: assert property (
      (read && address == PLL_CONTROL_IDX && FULL_VARIANT) |=> readValid_r
         && readData_r[1:0] == {$past(pfdBit_r), $past(resetBit_r)})
      else $error("control readback wrong");

   a_step_single: assert property (
      stepReq |=> phaseStep_r && phaseUp_r == ($past(wrWord[31:30]) == STEP_UP)
         ##1 (!phaseStep_r || $past(write && address == PHASE_STEP_CONTROL_IDX
                                    && (wrWord[31:30] == STEP_UP || wrWord[31:30] == STEP_DOWN))))
      else $error("step request not a single pulse");

   a_step_nop: assert property (
      (wrPhase && (wrWord[31:30] == 2'h0 || wrWord[31:30] == 2'h3)) |=> !phaseStep_r)
      else $error("no-op code issued a step");

   a_sel_all_out: assert property (
      (stepReq && wrWord[8:0] == SEL_ALL_OUT) |=> stepMask_r == {1'b0, {NUM_OUT_CNT{1'b1}}})
      else $error("all-output select decoded wrong");

   c_step_up:   cover property (stepReq && wrWord[31:30] == STEP_UP);
   c_step_down: cover property (stepReq && wrWord[31:30] == STEP_DOWN);
   c_pll_reset: cover property ($rose(pllReset_r));
   c_lock_lost: cover property ($fell(lockSync_r));

endmodule // pll_status_control_regs

`default_nettype wire

// [design/pll_regs_pkg.sv]
// Package of register offsets, field positions, reset values and codes for the PLL register block.
package pll_regs_pkg;

   // ----------------------------------------------------------------
   // Register word indices
   // ----------------------------------------------------------------
   localparam logic [1:0] PLL_STATUS_IDX         = 2'h0;
   localparam logic [1:0] PLL_CONTROL_IDX        = 2'h1;
   localparam logic [1:0] PHASE_STEP_CONTROL_IDX = 2'h2;
   localparam int         ADDR_W                 = 2;

   // ----------------------------------------------------------------
   // Register widths of the two variants
   // ----------------------------------------------------------------
   localparam int FULL_DATA_W    = 32;
   localparam int REDUCED_DATA_W = 16;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int LOCK_BIT      = 0;
   localparam int DONE_BIT      = 1;
   localparam int RESET_BIT     = 0;
   localparam int PFD_BIT       = 1;
   localparam int SEL_LSB       = 0;
   localparam int SEL_W         = 9;
   localparam int STEP_LSB      = 30;
   localparam int STEP_W        = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic       LOCK_RST    = 1'b1;
   localparam logic       DONE_RST    = 1'b0;
   localparam logic       RESET_RST   = 1'b0;
   localparam logic       PFD_RST     = 1'b1;
   localparam logic [8:0] SEL_RST     = 9'h000;
   localparam logic [1:0] STEP_RST    = 2'h0;

   // ----------------------------------------------------------------
   // Step codes and counter-select codes
   // ----------------------------------------------------------------
   localparam logic [1:0] STEP_UP   = 2'h1;
   localparam logic [1:0] STEP_DOWN = 2'h2;
   localparam logic [8:0] SEL_ALL_OUT  = 9'h000;
   localparam logic [8:0] SEL_FEEDBACK = 9'h001;
   localparam logic [8:0] SEL_OUT_BASE = 9'h100;
   localparam int         NUM_OUT_CNT  = 10;
   localparam int         MASK_W       = NUM_OUT_CNT + 1;

endpackage : pll_regs_pkg

// [verification/pll_model.sv]
// Behavioural PLL macro that answers the reset and phase-step requests of the register block.
`timescale 1ns/10ps
`default_nettype none

module pll_model (
   input  wire logic ref_clk,
   input  wire logic pllReset,
   input  wire logic phaseStep,
   output var  logic pllLocked,
   output var  logic pllShiftDone
);
   // ----------------------------------------------------------------
   // Lock and shift behaviour
   // ----------------------------------------------------------------
   logic [3:0] lockCnt_r = 4'h8;
   logic [1:0] doneCnt_r = 2'h0;
   initial pllLocked = 1'b1;
   initial pllShiftDone = 1'b0;

   // Lock falls at once on reset and returns nine cycles after release, like a slow relock.
   // The reset request is unknown until the block's first edge, so only a definite high
   // counts; otherwise the unknown would poison the counter and lock for the whole run.
   always @(posedge ref_clk) begin
      lockCnt_r <= (pllReset === 1'b1) ? 4'h0
                 : (lockCnt_r == 4'h8 ? lockCnt_r : lockCnt_r + 4'h1);
      pllLocked <= (pllReset !== 1'b1) && (lockCnt_r == 4'h8);
   end

   // Shift-done drops for each step and comes back three cycles later.
   always @(posedge ref_clk) begin
      if (phaseStep) begin
         doneCnt_r <= 2'h3;
         pllShiftDone <= 1'b0;
      end else if (doneCnt_r != 2'h0) begin
         doneCnt_r <= doneCnt_r - 2'h1;
         pllShiftDone <= (doneCnt_r == 2'h1);
      end
   end
endmodule // pll_model

`default_nettype wire

// [verification/tb.sv]
// Self-checking testbench for the PLL status and control register block.
`timescale 1ns/10ps
`default_nettype none

module tb;
   import pll_regs_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  address = 2'h0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writeData = 32'h0;
   logic [31:0] readData_r;
   logic        readValid_r, pllLocked, pllShiftDone, lockedConduit, shiftDoneConduit;
   logic        pllReset_r, pfdEnable_r, phaseStep_r, phaseUp_r;
   logic [8:0]  stepSel_r;
   logic [10:0] stepMask_r;
   logic [31:0] rdv;
   logic        stepSeen;
   int          n_fail = 0;
   int          n_tests = 0;

   // Free-running 125 MHz system clock.
   always #4 ref_clk = ~ref_clk;

   pll_status_control_regs u_pll_status_control_regs (
      .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writeData(writeData), .readData_r(readData_r), .readValid_r(readValid_r),
      .pllLocked(pllLocked), .pllShiftDone(pllShiftDone),
      .extResetReq(1'b0), .extPfdEnable(1'b1),
      .lockedConduit(lockedConduit), .shiftDoneConduit(shiftDoneConduit),
      .pllReset_r(pllReset_r), .pfdEnable_r(pfdEnable_r), .phaseStep_r(phaseStep_r),
      .phaseUp_r(phaseUp_r), .stepSel_r(stepSel_r), .stepMask_r(stepMask_r));

   pll_model u_pll_model (
      .ref_clk(ref_clk), .pllReset(pllReset_r), .phaseStep(phaseStep_r),
      .pllLocked(pllLocked), .pllShiftDone(pllShiftDone));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   // Word and bit comparisons, both counted.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkBit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One-cycle write; stepSeen samples the step pulse just after the taking edge.
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      write <= 1'b1;
      address <= a;
      writeData <= d;
      @(posedge ref_clk);
      write <= 1'b0;
      #1 stepSeen = phaseStep_r;
   endtask

   // One-cycle read; data is taken in the single cycle that readValid_r stands.
   task automatic rd(input logic [1:0] a);
      @(posedge ref_clk);
      read <= 1'b1;
      address <= a;
      @(posedge ref_clk);
      read <= 1'b0;
      #1 chkBit(readValid_r, 1'b1);
      rdv = readData_r;
   endtask

   // Relock is polled under a bound so a dead PLL path cannot hang the run.
   task automatic waitLock();
      for (int i = 0; i < 40; i++) begin
         rd(PLL_STATUS_IDX);
         if (rdv[LOCK_BIT] === 1'b1) return;
      end
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, rdv, 32'h1);
      results();
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic tReset();
      rd(PLL_STATUS_IDX);
      chk(rdv, 32'h1);
      rd(PLL_CONTROL_IDX);
      chk(rdv, 32'h2);
      chk({29'h0, pllReset_r, pfdEnable_r, phaseStep_r}, 32'h2);
      $display("test reset values done");
   endtask

   task automatic tRefused();
      wr(PLL_STATUS_IDX, 32'hffff_ffff);
      rd(PLL_STATUS_IDX);
      chk(rdv, 32'h1);
      rd(PLL_CONTROL_IDX);
      chk(rdv, 32'h2);
      chkBit(stepSeen, 1'b0);
      wr(2'h3, 32'h3);
      rd(2'h3);
      chk(rdv, 32'h0);
      $display("test refused writes done");
   endtask

   task automatic tControl();
      wr(PLL_CONTROL_IDX, 32'h0);
      @(posedge ref_clk);
      #1 chkBit(pfdEnable_r, 1'b0);
      rd(PLL_CONTROL_IDX);
      chk(rdv, 32'h0);
      wr(PLL_CONTROL_IDX, 32'h3);
      @(posedge ref_clk);
      #1 chkBit(pllReset_r, 1'b1);
      repeat (3) @(posedge ref_clk);
      #1 chkBit(lockedConduit, 1'b0);
      rd(PLL_STATUS_IDX);
      chkBit(rdv[LOCK_BIT], 1'b0);
      wr(PLL_CONTROL_IDX, 32'h2);
      waitLock();
      $display("test control done");
   endtask

   task automatic tStep();
      logic [8:0]  sels [7] = '{9'h000, 9'h001, 9'h100, 9'h109, 9'h105, 9'h002, 9'h10a};
      logic [10:0] masks [7] = '{11'h3ff, 11'h400, 11'h001, 11'h200, 11'h020, 11'h000, 11'h000};
      logic [1:0]  dir;
      for (int i = 0; i < 7; i++) begin
         dir = i[0] ? STEP_UP : STEP_DOWN;
         wr(PHASE_STEP_CONTROL_IDX, {dir, 21'h0, sels[i]});
         chkBit(stepSeen, 1'b1);
         chk({11'h0, phaseUp_r, stepSel_r, stepMask_r}, {11'h0, i[0], sels[i], masks[i]});
         @(posedge ref_clk);
         #1 chkBit(phaseStep_r, 1'b0);
         rd(PHASE_STEP_CONTROL_IDX);
         chk(rdv, {dir, 21'h0, sels[i]});
      end
      repeat (6) @(posedge ref_clk);
      rd(PLL_STATUS_IDX);
      chk(rdv, 32'h3);
      chkBit(shiftDoneConduit, 1'b1);
      wr(PHASE_STEP_CONTROL_IDX, {2'b00, 21'h0, 9'h100});
      chkBit(stepSeen, 1'b0);
      wr(PHASE_STEP_CONTROL_IDX, {2'b11, 21'h0, 9'h100});
      chkBit(stepSeen, 1'b0);
      $display("test phase steps done");
   endtask

   // Two writes on consecutive edges must give two pulses on consecutive cycles.
   task automatic tBackToBack();
      @(posedge ref_clk);
      write <= 1'b1;
      address <= PHASE_STEP_CONTROL_IDX;
      writeData <= {STEP_UP, 21'h0, 9'h100};
      @(posedge ref_clk);
      writeData <= {STEP_DOWN, 21'h0, 9'h101};
      #1 chkBit(phaseStep_r, 1'b1);
      @(posedge ref_clk);
      write <= 1'b0;
      #1 chkBit(phaseStep_r, 1'b1);
      chk({20'h0, phaseUp_r, stepMask_r}, 32'h002);
      @(posedge ref_clk);
      #1 chkBit(phaseStep_r, 1'b0);
      $display("test back to back steps done");
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      tReset();
      tRefused();
      tControl();
      tStep();
      tBackToBack();
      results();
   end
endmodule // tb

`default_nettype wire
